// ===== logic/cba_defines.svh
// shared constants for the cluster bus arbiter
`ifndef CBA_DEFINES_SVH
`define CBA_DEFINES_SVH
`define CBA_NUM_PROCS 8
`define CBA_ID_W 3
`define CBA_RESET_OWNER 3'h0
`endif

// ===== logic/cba_pkg.sv
// types for the cluster bus arbiter
package cba_pkg;
  // request agent states, gray coded along idle -> request -> own -> release
  typedef enum logic [1:0] {
    CBA_IDLE = 2'b00,
    CBA_REQ = 2'b01,
    CBA_OWN = 2'b11,
    CBA_DONE = 2'b10
  } cba_state_e;
endpackage

// ===== logic/cba_rr_pick.sv
// round-robin picker: first requester above the owner, wrapping, with the owner itself tried last
`timescale 1ns/1ns
module cba_rr_pick #(
  parameter int N = 8,
  parameter int W = 3
) (
  input wire logic [N-1:0] i_req, // candidate requesters, active high
  input wire logic [W-1:0] i_owner, // present owner id
  output logic o_any, // some candidate present
  output logic [W-1:0] o_pick // winning id
);
  // ---------------------------------------------------------------
  // search upward from owner+1 and wrap
  // ---------------------------------------------------------------
  always_comb begin
    logic [W-1:0] idx;
    idx = '0;
    o_any = 1'b0;
    o_pick = i_owner;
    for (int k = N; k >= 1; k--) begin
      idx = W'((int'(i_owner) + k) % N);
      if (i_req[idx]) begin
        o_any = 1'b1;
        o_pick = idx;
      end
    end
  end
endmodule // cba_rr_pick

// ===== logic/cba_arbiter.sv
// distributed bus arbiter node for one processor of the cluster
`timescale 1ns/1ns
`include "cba_defines.svh"
// Overview of operation
// - id zero owns bus after reset
// - equal priority passes round robin upward
// - decide from owner and request lines only
// - core access drives request and core priority
// - high dma drives dma priority unless core
// - rank host, core, dma, then plain
// - higher rank preempts current owner
// - no priority lines means id rotation
// - dma priority active while high dma pending
// - owner finishes transaction then drops request
// - normal dma waits while dma priority active
// - several dma priority go by rotation
// - high dma done drops both lines
// - rotation continues from preempting owner
// - owner drives its master flag low
// - core priority makes dma requesters withdraw
module cba_arbiter
  import cba_pkg::*;
#(
  parameter int NUM_PROCS = `CBA_NUM_PROCS,
  parameter int ID_W = `CBA_ID_W
) (
  input wire logic i_clock, // shared bus clock
  input wire logic i_resetn, // async reset, active low
  input wire logic [ID_W-1:0] i_proc_id, // static unique id
  input wire logic i_core_req, // core wants the bus
  input wire logic i_dma_req, // dma channel wants the bus
  input wire logic i_dma_high, // that dma channel is high priority
  input wire logic i_xfer_busy, // a transaction is in progress
  input wire logic [NUM_PROCS-1:0] i_bus_request_n, // all request lines, own included
  input wire logic i_host_bus_request_n, // host request
  input wire logic i_core_priority_access_n, // wired core priority of cluster
  input wire logic i_dma_priority_access_n, // wired dma priority of cluster
  output logic o_bus_request_n, // our request line
  output logic o_core_priority_access_n, // our core priority line
  output logic o_dma_priority_access_n, // our dma priority line
  output logic o_bus_owner_flag_n, // low while we own the bus
  output logic o_grant // we may run a transaction
);
  // ---------------------------------------------------------------
  // local state
  // ---------------------------------------------------------------
  logic [ID_W-1:0] owner_ff, nxt_owner;
  logic [ID_W-1:0] id_ff;
  cba_state_e state_ff;
  logic req_ff, cpa_ff, dpa_ff;
  logic [NUM_PROCS-1:0] req_hi;
  logic any_req;
  logic [ID_W-1:0] pick;
  logic host_act, cpa_act, dpa_act, owner_req;
  logic want, my_cpa, my_dpa, withdraw;
  logic self_owner;

  // ownership decode, shared by the agent and the flag
  function automatic logic is_owner(input logic [ID_W-1:0] owner, input logic [ID_W-1:0] id);
    return owner == id;
  endfunction

  assign self_owner = is_owner(owner_ff, id_ff);

  // active-low lines inverted once here; all feed bus-clock registers, and host_act also gates o_grant directly
  assign req_hi = ~i_bus_request_n;
  assign host_act = ~i_host_bus_request_n;
  assign cpa_act = ~i_core_priority_access_n;
  assign dpa_act = ~i_dma_priority_access_n;
  assign owner_req = req_hi[owner_ff];

  // ---------------------------------------------------------------
  // identifier capture
  // ---------------------------------------------------------------
  // sampled after reset release so a strap never feeds the async path
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      id_ff <= '0;
    end else begin
      id_ff <= i_proc_id;
    end
  end

  // ---------------------------------------------------------------
  // ownership tracking
  // ---------------------------------------------------------------
  // priority filtering is done by the requesters withdrawing, so the
  // picker only needs the request lines and the owner
  cba_rr_pick #(.N(NUM_PROCS), .W(ID_W)) u_pick (
    .i_req(req_hi),
    .o_any(any_req),
    .i_owner(owner_ff),
    .o_pick(pick)
  );

  // owner keeps the bus while requesting; otherwise rotate from it
  always_comb begin
    nxt_owner = owner_ff;
    if (!owner_req && any_req) begin
      nxt_owner = pick;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      owner_ff <= ID_W'(`CBA_RESET_OWNER);
    end else if (!host_act) begin
      owner_ff <= nxt_owner;
    end
  end

  // ---------------------------------------------------------------
  // request agent
  // ---------------------------------------------------------------
  assign my_cpa = i_core_req;
  assign my_dpa = !i_core_req && i_dma_req && i_dma_high;
  // lower ranks withdraw when someone else shows a higher class
  always_comb begin
    withdraw = 1'b0;
    if (host_act) begin
      withdraw = 1'b1;
    end else if (!my_cpa && cpa_act && !cpa_ff) begin
      withdraw = 1'b1;
    end else if (!my_cpa && !my_dpa && dpa_act && !dpa_ff) begin
      withdraw = 1'b1;
    end
  end
  assign want = (i_core_req || i_dma_req) && !withdraw;

  // owner may only let go between transactions
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= CBA_IDLE;
      req_ff <= 1'b0;
      cpa_ff <= 1'b0;
      dpa_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        CBA_IDLE: begin
          if (want) begin
            state_ff <= CBA_REQ;
            req_ff <= 1'b1;
            cpa_ff <= my_cpa;
            dpa_ff <= my_dpa;
          end
        end
        CBA_REQ: begin
          if (!want) begin
            state_ff <= CBA_IDLE;
            req_ff <= 1'b0;
            cpa_ff <= 1'b0;
            dpa_ff <= 1'b0;
          end else begin
            // class lines track demand while waiting, so a late change is shown
            cpa_ff <= my_cpa;
            dpa_ff <= my_dpa;
            if (self_owner && !host_act) begin
              state_ff <= CBA_OWN;
            end
          end
        end
        CBA_OWN: begin
          if ((!want || !(i_core_req || i_dma_req)) && !i_xfer_busy) begin
            state_ff <= CBA_DONE;
            req_ff <= 1'b0;
            cpa_ff <= 1'b0;
            dpa_ff <= 1'b0;
          end else begin
            cpa_ff <= my_cpa;
            dpa_ff <= my_dpa;
          end
        end
        CBA_DONE: begin
          state_ff <= CBA_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_bus_request_n = ~req_ff;
  assign o_core_priority_access_n = ~cpa_ff;
  assign o_dma_priority_access_n = ~dpa_ff;
  assign o_bus_owner_flag_n = ~self_owner;
  assign o_grant = (state_ff == CBA_OWN) && req_ff && !host_act;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_OWNER_HOLDS: assert property (@(posedge i_clock) disable iff (!i_resetn)
    owner_req && !host_act |=> owner_ff == $past(owner_ff))
    else $error("owner changed while owner still requesting");
  AST_ROTATE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !owner_req && any_req && !host_act |=> owner_ff == $past(pick))
    else $error("rotation did not move to picked id");
  AST_FLAG: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (owner_ff == id_ff) == !o_bus_owner_flag_n)
    else $error("master flag disagrees with owner");
  AST_DPA_NOT_CPA: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !(cpa_ff && dpa_ff))
    else $error("both priority lines driven");
  AST_CPA_WITH_REQ: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !o_core_priority_access_n |-> !o_bus_request_n)
    else $error("core priority without request");
  AST_NO_DROP_BUSY: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_ff == CBA_OWN && i_xfer_busy |=> state_ff == CBA_OWN)
    else $error("released bus mid transaction");
  AST_HOST_FREEZE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    host_act |-> !o_grant)
    else $error("grant while host holds bus");
  AST_DONE_DROPS: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_ff == CBA_DONE |-> o_bus_request_n && o_dma_priority_access_n)
    else $error("lines still driven after release");
  AST_CPA_WITHDRAW: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_ff != CBA_OWN || !i_xfer_busy) && cpa_act && !cpa_ff && !my_cpa
    |=> o_bus_request_n && o_dma_priority_access_n)
    else $error("dma requester kept lines under core priority");
  AST_DPA_WITHDRAW: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_ff != CBA_OWN || !i_xfer_busy) && dpa_act && !dpa_ff && !my_cpa && !my_dpa
    |=> o_bus_request_n)
    else $error("normal requester kept request under dma priority");
  AST_DPA_FOLLOWS: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_ff == CBA_REQ || state_ff == CBA_OWN) && want
    |=> o_dma_priority_access_n == !$past(my_dpa))
    else $error("dma priority line does not follow high dma demand");
  AST_GRANT_OWNER: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_grant |-> !o_bus_owner_flag_n)
    else $error("grant without master flag");
  AST_HOST_HOLDS: assert property (@(posedge i_clock) disable iff (!i_resetn)
    host_act |=> owner_ff == $past(owner_ff))
    else $error("owner moved while host requests");
endmodule // cba_arbiter

// ===== test/cba_peer_model.sv
// behavioural model of the peer processors and host on the shared bus
`timescale 1ns/1ns
module cba_peer_model (
  input wire logic i_clock, // shared bus clock
  input wire logic i_resetn, // async reset, active low
  input wire logic [7:0] i_peer_demand, // per-peer plain demand, active high
  input wire logic i_host_demand, // host wants the bus
  input wire logic i_core_demand, // peer two runs a core access
  input wire logic i_dpa_demand, // peer three runs a high priority dma
  output logic [7:0] o_bus_request_n, // peer request lines
  output logic o_host_bus_request_n, // host request line
  output logic o_core_priority_access_n, // peers' share of the core priority line
  output logic o_dma_priority_access_n // peers' share of the dma priority line
);
  // -----------------------------------------------------------------
  // request lines
  // -----------------------------------------------------------------
  // lines move just after the edge so the node never sees a race
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bus_request_n <= 8'hff;
      o_host_bus_request_n <= 1'h1;
      o_core_priority_access_n <= 1'h1;
      o_dma_priority_access_n <= 1'h1;
    end else begin
      o_bus_request_n <= ~(i_peer_demand | (i_core_demand ? 8'h04 : 8'h00) |
        (i_dpa_demand ? 8'h08 : 8'h00));
      o_dma_priority_access_n <= ~i_dpa_demand;
      o_host_bus_request_n <= ~i_host_demand;
      o_core_priority_access_n <= ~i_core_demand;
    end
  end
endmodule // cba_peer_model

// ===== test/cba_arbiter_tb_top.sv
// self-checking bench for one arbiter node among modelled peers
`timescale 1ns/1ns
module cba_arbiter_tb_top;
  logic clock, resetn, core_req, dma_req, dma_high, busy, host_d, core_d;
  logic dpa_d, peer_dpa_n;
  logic [7:0] peer_d, peer_req_n, bus_req_n;
  logic req_n, cpa_n, dpa_n, own_n, grant, host_n, peer_cpa_n;
  int miscompares = 0;
  int samples_checked = 0;
  // our node is id one, so its line sits in bit one
  assign bus_req_n = {peer_req_n[7:2], req_n, peer_req_n[0]};
  cba_peer_model u_cba_peer_model (.i_clock(clock), .i_resetn(resetn),
    .i_peer_demand(peer_d), .i_host_demand(host_d), .i_core_demand(core_d),
    .i_dpa_demand(dpa_d), .o_bus_request_n(peer_req_n), .o_host_bus_request_n(host_n),
    .o_core_priority_access_n(peer_cpa_n), .o_dma_priority_access_n(peer_dpa_n));
  cba_arbiter u_cba_arbiter (.i_clock(clock), .i_resetn(resetn), .i_proc_id(3'h1),
    .i_core_req(core_req), .i_dma_req(dma_req), .i_dma_high(dma_high),
    .i_xfer_busy(busy), .i_bus_request_n(bus_req_n), .i_host_bus_request_n(host_n),
    .i_core_priority_access_n(cpa_n & peer_cpa_n), .i_dma_priority_access_n(dpa_n & peer_dpa_n),
    .o_bus_request_n(req_n), .o_core_priority_access_n(cpa_n),
    .o_dma_priority_access_n(dpa_n), .o_bus_owner_flag_n(own_n), .o_grant(grant));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic sc_reset();
    check(own_n, 1'b1);
    check(req_n, 1'b1);
  endtask
  // owner zero holds while requesting; id one beats id two on release
  task automatic sc_rotate();
    peer_d = 8'h05;
    dma_req = 1'b1;
    busy = 1'b1;
    repeat (4) @(negedge clock);
    check(req_n, 1'b0);
    check(own_n, 1'b1);
    peer_d = 8'h04;
    for (int i = 0; i < 20 && own_n !== 1'b0; i++) @(negedge clock);
    check(own_n, 1'b0);
    @(negedge clock);
    check(grant, 1'b1);
    host_d = 1'b1;
    repeat (3) @(negedge clock);
    check(grant, 1'b0);
    host_d = 1'b0;
    dma_req = 1'b0;
    repeat (3) @(negedge clock);
    check(req_n, 1'b0);
    busy = 1'b0;
    for (int i = 0; i < 20 && req_n !== 1'b1; i++) @(negedge clock);
    check(req_n, 1'b1);
    peer_d = 8'h00;
  endtask
  // high dma request, withdrawn while a peer holds core priority
  task automatic sc_dma_high();
    dma_req = 1'b1;
    dma_high = 1'b1;
    repeat (4) @(negedge clock);
    check(req_n, 1'b0);
    check(dpa_n, 1'b0);
    core_d = 1'b1;
    for (int i = 0; i < 20 && req_n !== 1'b1; i++) @(negedge clock);
    check(req_n, 1'b1);
    check(dpa_n, 1'b1);
    core_d = 1'b0;
    for (int i = 0; i < 20 && dpa_n !== 1'b0; i++) @(negedge clock);
    check(dpa_n, 1'b0);
    dma_req = 1'b0;
    dma_high = 1'b0;
    for (int i = 0; i < 20 && req_n !== 1'b1; i++) @(negedge clock);
    check(req_n, 1'b1);
    check(dpa_n, 1'b1);
  endtask
  task automatic sc_core();
    repeat (2) @(negedge clock);
    core_req = 1'b1;
    repeat (3) @(negedge clock);
    check(req_n, 1'b0);
    check(cpa_n, 1'b0);
    core_req = 1'b0;
    for (int i = 0; i < 20 && req_n !== 1'b1; i++) @(negedge clock);
    check(cpa_n, 1'b1);
  endtask
  // a peer's high dma makes our normal dma stand back; rotation resumes from it
  task automatic sc_dma_rank();
    dma_req = 1'b1;
    repeat (3) @(negedge clock);
    check(req_n, 1'b0);
    dpa_d = 1'b1;
    for (int i = 0; i < 20 && req_n !== 1'b1; i++) @(negedge clock);
    check(req_n, 1'b1);
    repeat (3) @(negedge clock);
    check(req_n, 1'b1);
    check(own_n, 1'b1);
    dma_high = 1'b1;
    repeat (2) @(negedge clock);
    check(dpa_n, 1'b0);
    check(own_n, 1'b1);
    dpa_d = 1'b0;
    for (int i = 0; i < 20 && own_n !== 1'b0; i++) @(negedge clock);
    check(own_n, 1'b0);
    @(negedge clock);
    check(grant, 1'b1);
    dma_req = 1'b0;
    dma_high = 1'b0;
    for (int i = 0; i < 20 && req_n !== 1'b1; i++) @(negedge clock);
    check(req_n, 1'b1);
    check(dpa_n, 1'b1);
  endtask
  // -----------------------------------------------------------------
  // clock and main sequence
  // -----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {resetn, core_req, dma_req, dma_high, busy, host_d, core_d} = 7'h00;
    dpa_d = 1'b0;
    peer_d = 8'h00;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    repeat (2) @(negedge clock);
    sc_reset();
    sc_rotate();
    sc_dma_high();
    sc_core();
    sc_dma_rank();
    end_of_test();
  end
  // watchdog: a hang counts as a mismatch and still reaches the report
  initial begin
    repeat (5000) @(negedge clock);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule // cba_arbiter_tb_top
